// ==== rtdmb_params.svh ====
// constants of the rtd input register bank: offsets, fields, codes, detents
// assumes inclusion by the package, the register bank module and its checker only
`ifndef RTDMB_PARAMS_SVH
`define RTDMB_PARAMS_SVH

// most channels, coils and discrete inputs the state vectors can hold
`define RTDMB_MAX_CH 6
`define RTDMB_MAX_BITS 16

// mirror offsets into holding space, zero-based request addresses
`define RTDMB_MIR_DISC 16'h03e8
`define RTDMB_MIR_COIL 16'h07d0
`define RTDMB_MIR_IREG 16'h0bb8

// input register offsets
`define RTDMB_IR_STATUS 16'h0000
`define RTDMB_IR_RANGE0 16'h0001
`define RTDMB_IR_BREAK 16'h0004
`define RTDMB_IR_CHSTAT 16'h0005
`define RTDMB_IR_VALUE 16'h000b
`define RTDMB_IR_COUNT 16'h0011

// holding register offsets
`define RTDMB_HR_RANGE0 16'h0000
`define RTDMB_HR_BREAK 16'h0003

// module status field positions
`define RTDMB_BIT_WINK 14
`define RTDMB_BIT_DEFAULT 13

// field limits and reset values
`define RTDMB_RANGE_MAX 4'h9
`define RTDMB_RANGE_RST 4'h0
`define RTDMB_BREAK_RST 1'b0
`define RTDMB_FULL_SCALE 16'h7d00

// discrete word and coil write encodings
`define RTDMB_WORD_OFF 16'h0000
`define RTDMB_WORD_ON 16'hffff
`define RTDMB_COIL_ON 16'hff00

// function codes
`define RTDMB_FC_RD_COIL 8'h01
`define RTDMB_FC_RD_DISC 8'h02
`define RTDMB_FC_RD_HOLD 8'h03
`define RTDMB_FC_RD_IREG 8'h04
`define RTDMB_FC_WR_COIL 8'h05
`define RTDMB_FC_WR_HOLD 8'h06
`define RTDMB_FC_WR_MULT 8'h10

// exception codes, zero meaning a normal answer
`define RTDMB_EXC_NONE 8'h00
`define RTDMB_EXC_FUNC 8'h01
`define RTDMB_EXC_ADDR 8'h02
`define RTDMB_EXC_VALUE 8'h03

// break detents per sensor family, downscale then upscale
`define RTDMB_DN_PLATINUM_STANDARD_ALPHA 16'hf681
`define RTDMB_DN_PLATINUM_ALTERNATE_ALPHA 16'hf6a5
`define RTDMB_DN_NI 16'hf8e3
`define RTDMB_DN_CU 16'hf731
`define RTDMB_DN_OHM 16'h0000
`define RTDMB_UP_PLATINUM_STANDARD_ALPHA 16'h314a
`define RTDMB_UP_PLATINUM_ALTERNATE_ALPHA 16'h3085
`define RTDMB_UP_NI 16'h0d7f
`define RTDMB_UP_CU 16'h7fff
`define RTDMB_UP_OHM `RTDMB_FULL_SCALE

`endif

// ==== rtdmb_pkg.sv ====
// types shared by the rtd input register bank and its surroundings
// assumes rtdmb_params.svh sits in the same folder
`include "rtdmb_params.svh"

package rtdmb_pkg;

  // one word request from the protocol framer
  typedef struct packed {
    logic valid;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] wdata;
  } rtdmb_req_s;

  // answer to one request
  typedef struct packed {
    logic valid;
    logic [15:0] data;
    logic [7:0] exc;
  } rtdmb_rsp_s;

  // live state from the measurement path, all on the same clock
  typedef struct packed {
    logic wink;
    logic deflt;
    logic [`RTDMB_MAX_CH-1:0] brk;
    logic [`RTDMB_MAX_CH-1:0][1:0] status;
    logic [`RTDMB_MAX_CH-1:0][15:0] value;
    logic [`RTDMB_MAX_CH-1:0][15:0] count;
  } rtdmb_meas_s;

  // retained configuration image
  typedef struct packed {
    logic [2:0][3:0] range;
    logic brk_dn;
  } rtdmb_nv_s;

  // one word to commit to retained storage
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [15:0] data;
  } rtdmb_save_s;

  // sensor families selected by the range code
  typedef enum logic [2:0] {
    RTDMB_PLATINUM_STANDARD_ALPHA,
    RTDMB_PLATINUM_ALTERNATE_ALPHA,
    RTDMB_NI,
    RTDMB_CU,
    RTDMB_OHM
  } rtdmb_family_e;

  // whole state of the register bank
  typedef struct packed {
    logic loaded;
    rtdmb_nv_s cfg;
    logic [`RTDMB_MAX_BITS-1:0] coil;
    logic [`RTDMB_MAX_BITS-1:0] disc_m;
    logic [`RTDMB_MAX_BITS-1:0] disc_s;
    rtdmb_rsp_s rsp;
    rtdmb_save_s save;
  } rtdmb_state_s;

endpackage : rtdmb_pkg

// ==== rtdmb_regmap.sv ====
// register bank of the rtd input module with holding-space mirroring
// assumes a framer that splits each request into single-word requests,
// a measurement path on ref_clk_in and retained storage outside
//
// Functional notes
// - input registers mirrored at plus 3000
// - discrete inputs mirrored one word each
// - mirrored discrete word reads 0000h or ffffh
// - coils mirrored one word each
// - single-register preset 0000h or ff00h drives mirrored coil
// - counts are 16-bit two's complement
// - temperature is signed tenth of degree
// - downscale break forces per-family detent
// - upscale break forces per-family detent
// - discrete bits follow channel number
// - holding registers retained across power loss
// - status shows wink bit 14, default 13
// - range code in bits 3..0, 10-15 reserved
// - one range register per channel pair
// - break bit 0 zero means upscale
// - channel status two bits, rest zero
// - bad value exception 03, bad function 01
`timescale 1ns/1ps
`default_nettype none
`include "rtdmb_params.svh"

module rtdmb_regmap
  import rtdmb_pkg::*;
#(
  parameter int N_CH = 6,
  parameter int N_COIL = 16,
  parameter int N_DISC = 16
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // request and answer
  input wire rtdmb_req_s req_in,
  output var rtdmb_rsp_s rsp_out,
  // measurement path
  input wire rtdmb_meas_s meas_in,
  // discrete input pins
  input wire logic [`RTDMB_MAX_BITS-1:0] disc_in,
  // coil drive
  output logic [`RTDMB_MAX_BITS-1:0] coil_out,
  // retained storage
  input wire rtdmb_nv_s nv_image_in,
  output var rtdmb_save_s nv_save_out,
  // current configuration
  output var rtdmb_nv_s cfg_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  localparam logic [15:0] NCH_W = 16'(N_CH);
  localparam logic [15:0] NCOIL_W = 16'(N_COIL);
  localparam logic [15:0] NDISC_W = 16'(N_DISC);
  localparam logic [15:0] NPORT_W = 16'(N_CH / 2);

  // mask of the channels, coils or inputs that exist
  function automatic logic [15:0] fill_mask(input logic [15:0] n);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (16'(i) < n) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : fill_mask

  // family from the range code; two-wire codes repeat the families
  function automatic rtdmb_family_e family_of(input logic [3:0] code);
    logic [3:0] f;
    f = (code > 4'h4) ? 4'(code - 4'h5) : code;
    case (f)
      4'h0: return RTDMB_PLATINUM_STANDARD_ALPHA;
      4'h1: return RTDMB_PLATINUM_ALTERNATE_ALPHA;
      4'h2: return RTDMB_NI;
      4'h3: return RTDMB_CU;
      default: return RTDMB_OHM;
    endcase
  endfunction : family_of

  // clipped break value for a family and direction
  function automatic logic [15:0] detent(input rtdmb_family_e fam,
                                         input logic dn);
    logic [15:0] v;
    v = 16'h0000;
    case (fam)
      RTDMB_PLATINUM_STANDARD_ALPHA: v = dn ? `RTDMB_DN_PLATINUM_STANDARD_ALPHA : `RTDMB_UP_PLATINUM_STANDARD_ALPHA;
      RTDMB_PLATINUM_ALTERNATE_ALPHA: v = dn ? `RTDMB_DN_PLATINUM_ALTERNATE_ALPHA : `RTDMB_UP_PLATINUM_ALTERNATE_ALPHA;
      RTDMB_NI: v = dn ? `RTDMB_DN_NI : `RTDMB_UP_NI;
      RTDMB_CU: v = dn ? `RTDMB_DN_CU : `RTDMB_UP_CU;
      default: v = dn ? `RTDMB_DN_OHM : `RTDMB_UP_OHM;
    endcase
    return v;
  endfunction : detent

  // one input register; hit low means no such register
  function automatic logic [16:0] ireg(input logic [15:0] a,
                                       input rtdmb_nv_s cfg,
                                       input rtdmb_meas_s m);
    logic [15:0] d;
    logic hit;
    logic [15:0] ch;
    logic [2:0] chi;
    d = 16'h0000;
    hit = 1'b0;
    ch = 16'h0000;
    chi = 3'h0;
    if (a == `RTDMB_IR_STATUS) begin
      hit = 1'b1;
      d[`RTDMB_BIT_WINK] = m.wink;
      d[`RTDMB_BIT_DEFAULT] = m.deflt;
    end else if (a >= `RTDMB_IR_RANGE0 &&
                 a < 16'(`RTDMB_IR_RANGE0 + NPORT_W)) begin
      // one register per pair, third only on six channels
      ch = 16'(a - `RTDMB_IR_RANGE0);
      hit = 1'b1;
      d[3:0] = cfg.range[ch[1:0]];
    end else if (a == `RTDMB_IR_BREAK) begin
      hit = 1'b1;
      d[0] = cfg.brk_dn;
    end else if (a >= `RTDMB_IR_CHSTAT &&
                 a < 16'(`RTDMB_IR_CHSTAT + NCH_W)) begin
      ch = 16'(a - `RTDMB_IR_CHSTAT);
      chi = ch[2:0];
      hit = 1'b1;
      d[1:0] = m.status[chi];
    end else if (a >= `RTDMB_IR_VALUE &&
                 a < 16'(`RTDMB_IR_VALUE + NCH_W)) begin
      ch = 16'(a - `RTDMB_IR_VALUE);
      chi = ch[2:0];
      hit = 1'b1;
      d = m.value[chi];
      if (m.brk[chi]) begin
        // downscale detent when direction bit is set
        d = detent(family_of(cfg.range[chi[2:1]]), cfg.brk_dn);
      end
    end else if (a >= `RTDMB_IR_COUNT &&
                 a < 16'(`RTDMB_IR_COUNT + NCH_W)) begin
      ch = 16'(a - `RTDMB_IR_COUNT);
      chi = ch[2:0];
      hit = 1'b1;
      // two's complement count kept as delivered
      d = m.count[chi];
    end
    return {hit, d};
  endfunction : ireg

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------

  rtdmb_state_s s_q;
  rtdmb_state_s s_d;

  logic [15:0] coil_mask;
  logic [15:0] disc_mask;
  logic [16:0] ir_word;
  logic [15:0] mir_off;

  assign coil_mask = fill_mask(NCOIL_W);
  assign disc_mask = fill_mask(NDISC_W);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------

  // one request per cycle; answer and store update on the next edge
  always_comb begin
    s_d = s_q;
    s_d.rsp.valid = 1'b0;
    s_d.rsp.data = 16'h0000;
    s_d.rsp.exc = `RTDMB_EXC_NONE;
    s_d.save.valid = 1'b0;
    ir_word = 17'h00000;
    mir_off = 16'h0000;
    // pins pass two flops before anything reads them
    s_d.disc_m = disc_in;
    s_d.disc_s = s_q.disc_m;
    if (!s_q.loaded) begin
      // retained image restored right after reset
      s_d.cfg = nv_image_in;
      s_d.loaded = 1'b1;
    end else if (req_in.valid) begin
      s_d.rsp.valid = 1'b1;
      case (req_in.func)
        `RTDMB_FC_RD_COIL: begin
          // addressed coil lands in bit 0
          if (req_in.addr < NCOIL_W) begin
            s_d.rsp.data = (s_q.coil & coil_mask) >> req_in.addr;
          end else begin
            s_d.rsp.exc = `RTDMB_EXC_ADDR;
          end
        end
        `RTDMB_FC_RD_DISC: begin
          // active input reads as a one bit
          if (req_in.addr < NDISC_W) begin
            s_d.rsp.data = (s_q.disc_s & disc_mask) >> req_in.addr;
          end else begin
            s_d.rsp.exc = `RTDMB_EXC_ADDR;
          end
        end
        `RTDMB_FC_RD_IREG: begin
          ir_word = ireg(req_in.addr, s_q.cfg, meas_in);
          s_d.rsp.data = ir_word[15:0];
          if (!ir_word[16]) begin
            s_d.rsp.exc = `RTDMB_EXC_ADDR;
          end
        end
        `RTDMB_FC_RD_HOLD: begin
          if (req_in.addr >= `RTDMB_HR_RANGE0 &&
              req_in.addr < 16'(`RTDMB_HR_RANGE0 + NPORT_W)) begin
            mir_off = 16'(req_in.addr - `RTDMB_HR_RANGE0);
            s_d.rsp.data = {12'h000, s_q.cfg.range[mir_off[1:0]]};
          end else if (req_in.addr == `RTDMB_HR_BREAK) begin
            s_d.rsp.data = {15'h0000, s_q.cfg.brk_dn};
          end else if (req_in.addr >= `RTDMB_MIR_DISC &&
                       req_in.addr < 16'(`RTDMB_MIR_DISC + NDISC_W)) begin
            // one whole word per discrete input
            mir_off = 16'(req_in.addr - `RTDMB_MIR_DISC);
            // all ones when on, zero when off
            s_d.rsp.data = s_q.disc_s[mir_off[3:0]] ?
                           `RTDMB_WORD_ON : `RTDMB_WORD_OFF;
          end else if (req_in.addr >= `RTDMB_MIR_COIL &&
                       req_in.addr < 16'(`RTDMB_MIR_COIL + NCOIL_W)) begin
            // coils read back like discrete words
            mir_off = 16'(req_in.addr - `RTDMB_MIR_COIL);
            s_d.rsp.data = s_q.coil[mir_off[3:0]] ?
                           `RTDMB_WORD_ON : `RTDMB_WORD_OFF;
          end else if (req_in.addr >= `RTDMB_MIR_IREG) begin
            // input register at offset, format unchanged
            ir_word = ireg(16'(req_in.addr - `RTDMB_MIR_IREG),
                           s_q.cfg, meas_in);
            s_d.rsp.data = ir_word[15:0];
            if (!ir_word[16]) begin
              s_d.rsp.exc = `RTDMB_EXC_ADDR;
            end
          end else begin
            s_d.rsp.exc = `RTDMB_EXC_ADDR;
          end
        end
        `RTDMB_FC_WR_COIL: begin
          if (req_in.addr >= NCOIL_W) begin
            s_d.rsp.exc = `RTDMB_EXC_ADDR;
          end else if (req_in.wdata == `RTDMB_COIL_ON) begin
            s_d.coil[req_in.addr[3:0]] = 1'b1;
            s_d.rsp.data = req_in.wdata;
          end else if (req_in.wdata == `RTDMB_WORD_OFF) begin
            s_d.coil[req_in.addr[3:0]] = 1'b0;
            s_d.rsp.data = req_in.wdata;
          end else begin
            s_d.rsp.exc = `RTDMB_EXC_VALUE;
          end
        end
        `RTDMB_FC_WR_HOLD, `RTDMB_FC_WR_MULT: begin
          s_d.rsp.data = req_in.wdata;
          if (req_in.addr >= `RTDMB_MIR_COIL &&
              req_in.addr < 16'(`RTDMB_MIR_COIL + NCOIL_W)) begin
            mir_off = 16'(req_in.addr - `RTDMB_MIR_COIL);
            if (req_in.func == `RTDMB_FC_WR_MULT) begin
              // multi-register write into coil mirror refused
              s_d.rsp.exc = `RTDMB_EXC_FUNC;
            end else if (req_in.wdata == `RTDMB_COIL_ON) begin
              s_d.coil[mir_off[3:0]] = 1'b1;
            end else if (req_in.wdata == `RTDMB_WORD_OFF) begin
              s_d.coil[mir_off[3:0]] = 1'b0;
            end else begin
              s_d.rsp.exc = `RTDMB_EXC_VALUE;
            end
          end else if (req_in.addr >= `RTDMB_HR_RANGE0 &&
                       req_in.addr < 16'(`RTDMB_HR_RANGE0 + NPORT_W)) begin
            mir_off = 16'(req_in.addr - `RTDMB_HR_RANGE0);
            // reserved codes and upper bits refused
            if (req_in.wdata > {12'h000, `RTDMB_RANGE_MAX}) begin
              s_d.rsp.exc = `RTDMB_EXC_VALUE;
            end else begin
              s_d.cfg.range[mir_off[1:0]] = req_in.wdata[3:0];
              // accepted word goes to retained storage
              s_d.save.valid = 1'b1;
            end
          end else if (req_in.addr == `RTDMB_HR_BREAK) begin
            // only bit 0 may be set
            if (req_in.wdata[15:1] != 15'h0000) begin
              s_d.rsp.exc = `RTDMB_EXC_VALUE;
            end else begin
              s_d.cfg.brk_dn = req_in.wdata[0];
              s_d.save.valid = 1'b1;
            end
          end else begin
            s_d.rsp.exc = `RTDMB_EXC_ADDR;
          end
        end
        default: begin
          s_d.rsp.exc = `RTDMB_EXC_FUNC;
        end
      endcase
      if (s_d.rsp.exc != `RTDMB_EXC_NONE) begin
        s_d.rsp.data = 16'h0000;
      end
      s_d.save.addr = req_in.addr;
      s_d.save.data = req_in.wdata;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // reset loads constants; the retained image follows one edge later
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
      s_q.cfg.range <= {3{`RTDMB_RANGE_RST}};
      s_q.cfg.brk_dn <= `RTDMB_BREAK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign rsp_out = s_q.rsp;
  assign coil_out = s_q.coil;
  assign nv_save_out = s_q.save;
  assign cfg_out = s_q.cfg;

endmodule : rtdmb_regmap
`default_nettype wire

// ==== rtdmb_regmap_chk.sv ====
// checker of the rtd register bank: answer timing, writes, read fields
// assumes binding to rtdmb_regmap, one clock, active-low async reset
`timescale 1ns/1ps
`default_nettype none
`include "rtdmb_params.svh"

module rtdmb_regmap_chk
  import rtdmb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // request and answer
  input wire rtdmb_req_s req_in,
  input wire rtdmb_rsp_s rsp_out,
  // state seen at the ports
  input wire rtdmb_meas_s meas_in,
  input wire logic [`RTDMB_MAX_BITS-1:0] coil_out,
  input wire rtdmb_nv_s nv_image_in,
  input wire rtdmb_save_s nv_save_out,
  input wire rtdmb_nv_s cfg_out
);
  // ------------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------------
  // set at the first edge after reset, once the image has been loaded
  logic live_q;
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // a request the bank must take, and the two write targets
  sequence take_s;
    live_q && req_in.valid;
  endsequence
  sequence coil_wr_s;
    take_s ##0 (req_in.func == 8'h06 && req_in.addr[15:4] == 12'h07d);
  endsequence
  sequence range_wr_s;
    take_s ##0 (req_in.func == 8'h06 && req_in.addr < 16'h0003);
  endsequence

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  answer_next_a: assert property (take_s |=> rsp_out.valid)
    else $error("request not answered one cycle later");
  no_stray_a: assert property (rsp_out.valid |->
    $past(req_in.valid) && $past(live_q))
    else $error("answer without a taken request");
  restore_img_a: assert property (!live_q |=>
    cfg_out == $past(nv_image_in))
    else $error("retained image not restored");
  coil_on_a: assert property (coil_wr_s ##0 req_in.wdata == 16'hff00
    |=> coil_out[$past(req_in.addr[3:0])] && rsp_out.exc == 8'h00)
    else $error("coil preset on not applied");
  coil_off_a: assert property (coil_wr_s ##0 req_in.wdata == 16'h0
    |=> !coil_out[$past(req_in.addr[3:0])])
    else $error("coil preset off not applied");
  coil_bad_a: assert property (coil_wr_s ##0
    (req_in.wdata != 16'h0 && req_in.wdata != 16'hff00)
    |=> rsp_out.exc == 8'h03 && $stable(coil_out))
    else $error("bad coil word not refused");
  range_ok_a: assert property (range_wr_s ##0 req_in.wdata <= 16'd9
    |=> nv_save_out.valid && rsp_out.exc == 8'h00 &&
    cfg_out.range[$past(req_in.addr[1:0])] == $past(req_in.wdata[3:0]))
    else $error("range write not stored and saved");
  range_bad_a: assert property (range_wr_s ##0 req_in.wdata > 16'd9
    |=> rsp_out.exc == 8'h03 && !nv_save_out.valid && $stable(cfg_out))
    else $error("reserved range code not refused");
  bad_func_a: assert property (take_s ##0 !(req_in.func inside
    {[8'h01:8'h06], 8'h0f, 8'h10, 8'h11}) |=> rsp_out.exc == 8'h01)
    else $error("unsupported function not refused");
  status_word_a: assert property (take_s ##0
    (req_in.func == 8'h04 && req_in.addr == 16'h0) |=> rsp_out.data ==
    {1'b0, $past(meas_in.wink), $past(meas_in.deflt), 13'h0})
    else $error("module status word wrong");
  disc_word_a: assert property (take_s ##0 (req_in.func == 8'h03 &&
    req_in.addr >= 16'h03e8 && req_in.addr < 16'h03f8)
    |=> rsp_out.data == 16'h0 || rsp_out.data == 16'hffff)
    else $error("mirrored discrete word not all zero or all one");
endmodule : rtdmb_regmap_chk

bind rtdmb_regmap rtdmb_regmap_chk chk (
  .ref_clk_in, .resetn_in, .req_in, .rsp_out, .meas_in, .coil_out,
  .nv_image_in, .nv_save_out, .cfg_out
);
`default_nettype wire

// ==== rtdmb_client.sv ====
// client model: issues one-word requests and collects the answers
// assumes the bank answers exactly one cycle after taking a request
`timescale 1ns/1ps
`default_nettype none

module rtdmb_client
  import rtdmb_pkg::*;
(
  // clock
  input wire logic ref_clk_in,
  // request and answer
  output var rtdmb_req_s req_out,
  input wire rtdmb_rsp_s rsp_in
);
  initial req_out = '0;

  // ------------------------------------------------------------------
  // one transfer
  // ------------------------------------------------------------------
  // single word
  // held across the taking edge; afterwards the lines carry inverted
  // junk so a bank that samples late never sees a clean copy
  task automatic send(input logic [7:0] f, input logic [15:0] a,
      input logic [15:0] w, output rtdmb_rsp_s r);
    @(negedge ref_clk_in);
    req_out <= {1'b1, f, a, w};
    @(negedge ref_clk_in);
    r = rsp_in;
    req_out <= {1'b0, ~f, ~a, ~w};
  endtask : send
endmodule : rtdmb_client
`default_nettype wire

// ==== tb_rtdmb_regmap.sv ====
// self-checking bench of the rtd register bank
// assumes the client model and checker files are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_rtdmb_regmap
  import rtdmb_pkg::*;
;
  logic ref_clk_in;
  logic resetn_in;
  rtdmb_req_s req;
  rtdmb_rsp_s rsp;
  rtdmb_rsp_s r;
  rtdmb_meas_s meas;
  logic [15:0] disc;
  logic [15:0] coil;
  rtdmb_nv_s nv_img;
  rtdmb_nv_s cfg;
  rtdmb_save_s save;
  int n_fail = 0;
  int n_tests = 0;
  // break detents by family: platinum std, platinum alt, nickel, copper, ohm
  logic [15:0] dn_tab [5] = '{16'd63105, 16'd63141, 16'd63715, 16'd63281,
    16'd0};
  logic [15:0] up_tab [5] = '{16'd12618, 16'd12421, 16'd3455, 16'd32767,
    16'd32000};

  rtdmb_regmap dut (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .req_in(req),
    .rsp_out(rsp), .meas_in(meas), .disc_in(disc), .coil_out(coil),
    .nv_image_in(nv_img), .nv_save_out(save), .cfg_out(cfg)
  );
  rtdmb_client cli (
    .ref_clk_in(ref_clk_in), .req_out(req), .rsp_in(rsp)
  );

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one transfer; answer must be valid with the given word and code
  task automatic xfer(input logic [7:0] f, input logic [15:0] a,
      input logic [15:0] w, input logic [15:0] d, input logic [7:0] e);
    cli.send(f, a, w, r);
    check({15'h0, r.valid}, 16'h1);
    check(r.data, d);
    check({8'h0, r.exc}, {8'h0, e});
  endtask : xfer

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // clock of 100 ns
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  // watchdog well beyond the roughly 250 cycles the tests need
  initial begin
    #200_000;
    n_fail++;
    stop_test();
  end

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    resetn_in = 1'b0;
    meas = '0;
    disc = 16'h0;
    nv_img = {4'h7, 4'h3, 4'h1, 1'b1};
    repeat (4) @(negedge ref_clk_in);
    check(coil, 16'h0);
    resetn_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    check({3'h0, cfg}, {3'h0, nv_img});
    for (int i = 0; i < 3; i++) begin
      xfer(8'h04, 16'(i + 1), 16'h0, {12'h0, nv_img.range[i]}, 8'h0);
      xfer(8'h03, 16'(i), 16'h0, {12'h0, nv_img.range[i]}, 8'h0);
    end
    xfer(8'h04, 16'h0004, 16'h0, 16'h0001, 8'h0);
    meas.wink = 1'b1;
    xfer(8'h04, 16'h0000, 16'h0, 16'h4000, 8'h0);
    meas.wink = 1'b0;
    meas.deflt = 1'b1;
    xfer(8'h03, 16'd3000, 16'h0, 16'h2000, 8'h0);
    for (int s = 0; s < 4; s++) begin
      meas.status[0] = 2'(s);
      xfer(8'h04, 16'h0005, 16'h0, 16'(s), 8'h0);
    end
    xfer(8'h03, 16'd3005, 16'h0, 16'h0003, 8'h0);
    meas.value[0] = 16'h8123;
    xfer(8'h04, 16'h000b, 16'h0, 16'h8123, 8'h0);
    xfer(8'h03, 16'd3011, 16'h0, 16'h8123, 8'h0);
    // detents for every code and direction
    meas.brk[0] = 1'b1;
    for (int c = 0; c < 10; c++) begin
      for (int d = 0; d < 2; d++) begin
        xfer(8'h06, 16'h0000, 16'(c), 16'(c), 8'h0);
        xfer(8'h06, 16'h0003, 16'(d), 16'(d), 8'h0);
        xfer(8'h04, 16'h000b, 16'h0, d ? dn_tab[c % 5] : up_tab[c % 5],
          8'h0);
      end
    end
    for (int c = 10; c < 16; c++) begin
      xfer(8'h06, 16'h0001, 16'(c), 16'h0, 8'h03);
    end
    xfer(8'h06, 16'h0003, 16'h0002, 16'h0, 8'h03);
    check({12'h0, cfg.range[1]}, 16'h0003);
    check({15'h0, save.valid}, 16'h0);
    // accepted multi-register word pulses the save port once
    xfer(8'h10, 16'h0002, 16'h0003, 16'h0003, 8'h0);
    check({15'h0, save.valid}, 16'h1);
    check(save.addr, 16'h0002);
    check(save.data, 16'h0003);
    check({12'h0, cfg.range[2]}, 16'h0003);
    // raw count and a missing input register
    meas.count[0] = 16'hfc18;
    xfer(8'h04, 16'h0011, 16'h0, 16'hfc18, 8'h0);
    xfer(8'h04, 16'h0017, 16'h0, 16'h0, 8'h02);
    // channel 3 takes its family from the second port
    meas.brk[3] = 1'b1;
    xfer(8'h04, 16'h000e, 16'h0, dn_tab[3], 8'h0);
    // discrete inputs, after the pin synchroniser
    disc = 16'h0005;
    repeat (3) @(negedge ref_clk_in);
    for (int k = 0; k < 4; k++) begin
      xfer(8'h03, 16'd1000 + 16'(k), 16'h0, disc[k] ? 16'hffff : 16'h0,
        8'h0);
    end
    xfer(8'h02, 16'h0000, 16'h0, 16'h0005, 8'h0);
    xfer(8'h02, 16'h0002, 16'h0, 16'h0001, 8'h0);
    xfer(8'h06, 16'd2003, 16'hff00, 16'hff00, 8'h0);
    check(coil, 16'h0008);
    xfer(8'h03, 16'd2003, 16'h0, 16'hffff, 8'h0);
    xfer(8'h01, 16'h0000, 16'h0, 16'h0008, 8'h0);
    xfer(8'h06, 16'd2003, 16'h1234, 16'h0, 8'h03);
    xfer(8'h10, 16'd2003, 16'h0000, 16'h0, 8'h01);
    check(coil, 16'h0008);
    xfer(8'h06, 16'd2003, 16'h0000, 16'h0000, 8'h0);
    check(coil, 16'h0);
    xfer(8'h07, 16'h0000, 16'h0, 16'h0, 8'h01);
    xfer(8'h06, 16'd3000, 16'h0001, 16'h0, 8'h02);
    // direct coil function, then a reset in mid-run drops the coil
    xfer(8'h05, 16'h0002, 16'h1234, 16'h0, 8'h03);
    xfer(8'h05, 16'h0002, 16'hff00, 16'hff00, 8'h0);
    check(coil, 16'h0004);
    resetn_in = 1'b0;
    @(negedge ref_clk_in);
    check(coil, 16'h0);
    nv_img = {4'h2, 4'h6, 4'h4, 1'b0};
    resetn_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    check({3'h0, cfg}, {3'h0, nv_img});
    xfer(8'h03, 16'h0001, 16'h0, 16'h0006, 8'h0);
    xfer(8'h04, 16'h0004, 16'h0, 16'h0000, 8'h0);
    stop_test();
  end
endmodule : tb_rtdmb_regmap
`default_nettype wire
